// ===== rtl/burst_bus_pkg.sv
// constants and types shared by the burst bus master files
// assumes one clock domain on clk_i at 100 MHz, synchronous active-high reset
// Behaviour
// - internal clock is the system clock divided by two; each state spans two periods.
// - upper sixteen address bits held stable on dedicated lines for whole burst.
// - low address on shared lines in address state, sixteen-bit data afterwards.
// - word address bits 3 to 1 duplicated, then incremented per burst word.
// - address latch strobe high in address state, low from the first data state.
// - address latch strobe floats while bus is held.
// - address status strobe low each address state, high after; high in reset.
// - write or read flag shown in address state and held through data states.
// - data enable low during data states; high throughout reset.
// - own drivers off on reads in the same cycle data enable falls; its rise means data captured.
// - direction low for reads and acknowledges, high for writes.
// - direction never changes while data enable is low; high during reset.
// - no ready in a data state inserts a wait state.
// - bursts of one to eight half-words, up to sixteen bytes.
// - hold request floats bus, raises acknowledge; removal resumes normal states.
package burst_bus_pkg;
   localparam int unsigned DATA_W      = 16;
   localparam int unsigned ADDR_W      = 32;
   localparam int unsigned FIFO_DEPTH  = 8;
   localparam int unsigned MAX_BEATS   = 8;
   localparam int unsigned CLK_DIV     = 2;
   localparam int unsigned UPPER_LSB   = 16;
   localparam int unsigned WORD_LSB    = 1;
   localparam int unsigned WORD_MSB    = 3;
   localparam logic        DIR_RST     = 1'b1;
   localparam logic        STROBE_IDLE = 1'b1;

   typedef enum logic [1:0] {
      KIND_READ,
      KIND_WRITE,
      KIND_INTACK
   } kind_t;

   typedef enum {
      ST_IDLE,
      ST_ADDRESS,
      ST_DATA,
      ST_HOLD
   } bus_state_t;
endpackage

// ===== rtl/phase_divider.sv
// divide-by-two phase generator for the internal processor clock
// assumes the system clock feeds clk_i directly
`timescale 1ns/100ps
module phase_divider (
   input  wire logic clk_i,
   input  wire logic sys_rst_i,
   output logic      phase_o
);
   import burst_bus_pkg::*;
   logic phase_r;
   logic phase_nxt;

   // toggles every rising input edge; phase high marks the end of an internal cycle
   always_comb begin
      phase_nxt = ~phase_r;
   end

   always_ff @(posedge clk_i) begin
      if (sys_rst_i) begin
         phase_r <= 1'b0;
      end else begin
         phase_r <= phase_nxt;
      end
   end

   assign phase_o = phase_r;

   property p_phase_alt;
      @(posedge clk_i) disable iff (sys_rst_i) phase_r |=> !phase_r;
   endproperty
   a_phase_alt: assert property (p_phase_alt) else $error("phase not halved");
endmodule // phase_divider

// ===== rtl/data_fifo.sv
// synchronous fifo with valid/ready on both sides
// assumes both sides on the same clock
`timescale 1ns/100ps
module data_fifo #(
   parameter int unsigned WIDTH = 16,
   parameter int unsigned DEPTH = 8
) (
   input  wire logic             clk_i,
   input  wire logic             sys_rst_i,
   input  wire logic [WIDTH-1:0] in_data_i,
   input  wire logic             in_valid_i,
   output logic                  in_ready_o,
   output logic      [WIDTH-1:0] out_data_o,
   output logic                  out_valid_o,
   input  wire logic             out_ready_i
);
   localparam int unsigned AW = $clog2(DEPTH);
   logic [WIDTH-1:0] mem_r [DEPTH];
   logic [AW-1:0]    wr_r, wr_nxt, rd_r, rd_nxt;
   logic [AW:0]      cnt_r, cnt_nxt;
   logic             push, pop;
   logic             room_r, room_nxt;

   // count-based full and empty; no pass-through, so ready is honest
   always_comb begin
      push    = in_valid_i && room_r;
      pop     = out_ready_i && (cnt_r != '0);
      wr_nxt  = push ? wr_r + AW'(1) : wr_r;
      rd_nxt  = pop ? rd_r + AW'(1) : rd_r;
      cnt_nxt = cnt_r + (AW+1)'(push) - (AW+1)'(pop);
      // room is registered so input ready leaves the block straight from a flop
      room_nxt = cnt_nxt != (AW+1)'(DEPTH);
   end

   always_ff @(posedge clk_i) begin
      if (sys_rst_i) begin
         wr_r  <= '0;
         rd_r  <= '0;
         cnt_r <= '0;
         room_r <= 1'b1;
      end else begin
         wr_r  <= wr_nxt;
         rd_r  <= rd_nxt;
         cnt_r <= cnt_nxt;
         room_r <= room_nxt;
      end
   end

   // storage carries no reset
   always_ff @(posedge clk_i) begin
      if (push) begin
         mem_r[wr_r] <= in_data_i;
      end
   end

   assign in_ready_o  = room_r;
   assign out_valid_o = cnt_r != '0;
   assign out_data_o  = mem_r[rd_r];
endmodule // data_fifo

// ===== rtl/burst_bus_master.sv
// multiplexed address/data burst bus master with wait states and hold
// assumes requests and write data from same-clock logic; pins sampled twice
`timescale 1ns/100ps
module burst_bus_master (
   input  wire logic                             clk_i,
   input  wire logic                             sys_rst_i,
   // request side
   input  wire logic                             req_valid_i,
   output logic                                  req_ready_o,
   input  wire burst_bus_pkg::kind_t             req_kind_i,
   input  wire logic [burst_bus_pkg::ADDR_W-1:0] req_addr_i,
   input  wire logic [3:0]                       req_beats_i,
   input  wire logic [burst_bus_pkg::DATA_W-1:0] wdata_i,
   input  wire logic                             wdata_valid_i,
   output logic                                  wdata_ready_o,
   output logic      [burst_bus_pkg::DATA_W-1:0] rdata_o,
   output logic                                  rdata_valid_o,
   output logic                                  done_o,
   // bus pins
   output logic      [15:0]                      upper_address_lines_o,
   output logic                                  upper_address_oe_o,
   input  wire logic [15:0]                      shared_address_data_lines_i,
   output logic      [15:0]                      shared_address_data_lines_o,
   output logic                                  shared_address_data_oe_o,
   output logic      [2:0]                       burst_word_address_lines_o,
   output logic                                  address_latch_o,
   output logic                                  address_latch_oe_o,
   output logic                                  address_status_strobe_n_o,
   output logic                                  write_not_read_o,
   output logic                                  data_enable_n_o,
   output logic                                  transfer_direction_o,
   output logic                                  strobes_oe_o,
   input  wire logic                             ready_n_i,
   input  wire logic                             hold_request_i,
   output logic                                  hold_acknowledge_o
);
   import burst_bus_pkg::*;

   logic phase;
   logic [DATA_W-1:0] fifo_data;
   logic              fifo_valid;
   logic              fifo_pop;

   phase_divider u_div (
      .clk_i     (clk_i),
      .sys_rst_i (sys_rst_i),
      .phase_o   (phase)
   );

   // write data buffered so the source can run ahead of bus waits
   data_fifo #(.WIDTH(DATA_W), .DEPTH(FIFO_DEPTH)) u_fifo (
      .clk_i       (clk_i),
      .sys_rst_i   (sys_rst_i),
      .in_data_i   (wdata_i),
      .in_valid_i  (wdata_valid_i),
      .in_ready_o  (wdata_ready_o),
      .out_data_o  (fifo_data),
      .out_valid_o (fifo_valid),
      .out_ready_i (fifo_pop)
   );

   // pin synchronisers: first stage read only by the second
   logic [15:0] ad_s1_r, ad_s2_r;
   logic        rdy_s1_r, rdy_s2_r, hold_s1_r, hold_s2_r;
   always_ff @(posedge clk_i) begin
      if (sys_rst_i) begin
         ad_s1_r   <= '0;
         ad_s2_r   <= '0;
         rdy_s1_r  <= 1'b1;
         rdy_s2_r  <= 1'b1;
         hold_s1_r <= 1'b0;
         hold_s2_r <= 1'b0;
      end else begin
         ad_s1_r   <= shared_address_data_lines_i;
         ad_s2_r   <= ad_s1_r;
         rdy_s1_r  <= ready_n_i;
         rdy_s2_r  <= rdy_s1_r;
         hold_s1_r <= hold_request_i;
         hold_s2_r <= hold_s1_r;
      end
   end

   // is this transfer driving data out
   function automatic logic is_write(input kind_t k);
      return k == KIND_WRITE;
   endfunction

   bus_state_t        st_r, st_nxt;
   kind_t             kind_r, kind_nxt;
   logic [ADDR_W-1:0] addr_r, addr_nxt;
   logic [2:0]        word_r, word_nxt;
   logic [3:0]        left_r, left_nxt;
   logic              hold_acknowledge_r, hold_acknowledge_nxt;
   logic              ale_r, ale_nxt, as_n_r, as_n_nxt, den_n_r, den_n_nxt;
   logic              dir_r, dir_nxt, wnr_r, wnr_nxt, oe_r, oe_nxt, pins_oe_r, pins_oe_nxt;
   logic [15:0]       ad_out_r, ad_out_nxt;
   logic [DATA_W-1:0] rdata_r, rdata_nxt;
   logic              rvalid_r, rvalid_nxt, done_r, done_nxt, rready_r, rready_nxt;
   logic              beat_ok;

   // bus sequencer; states advance only at the end of an internal cycle
   always_comb begin
      st_nxt      = st_r;
      kind_nxt    = kind_r;
      addr_nxt    = addr_r;
      word_nxt    = word_r;
      left_nxt    = left_r;
      hold_acknowledge_nxt    = hold_acknowledge_r;
      ale_nxt     = ale_r;
      as_n_nxt    = as_n_r;
      den_n_nxt   = den_n_r;
      dir_nxt     = dir_r;
      wnr_nxt     = wnr_r;
      oe_nxt      = oe_r;
      pins_oe_nxt = pins_oe_r;
      ad_out_nxt  = ad_out_r;
      rdata_nxt   = rdata_r;
      rvalid_nxt  = 1'b0;
      done_nxt    = 1'b0;
      rready_nxt  = 1'b0;
      fifo_pop    = 1'b0;
      // a write beat needs buffered data, else it stretches like a wait
      beat_ok     = !rdy_s2_r && (!is_write(kind_r) || fifo_valid);
      if (phase) begin
         unique case (st_r)
            ST_IDLE: begin
               if (hold_s2_r) begin
                  st_nxt      = ST_HOLD;
                  pins_oe_nxt = 1'b0;
                  oe_nxt      = 1'b0;
                  hold_acknowledge_nxt    = 1'b1;
               end else if (req_valid_i) begin
                  st_nxt     = ST_ADDRESS;
                  rready_nxt = 1'b1;
                  kind_nxt   = req_kind_i;
                  addr_nxt   = req_addr_i;
                  word_nxt   = req_addr_i[WORD_MSB:WORD_LSB];
                  // zero beats treated as one; more than eight clipped
                  left_nxt   = (req_beats_i == 4'h0) ? 4'h1 :
                               (req_beats_i > 4'(MAX_BEATS)) ? 4'(MAX_BEATS) : req_beats_i;
                  ale_nxt    = 1'b1;
                  as_n_nxt   = 1'b0;
                  wnr_nxt    = is_write(req_kind_i);
                  dir_nxt    = is_write(req_kind_i);
                  ad_out_nxt = req_addr_i[15:0];
                  oe_nxt     = 1'b1;
               end
            end
            ST_ADDRESS: begin
               st_nxt    = ST_DATA;
               ale_nxt   = 1'b0;
               as_n_nxt  = 1'b1;
               den_n_nxt = 1'b0;
               // reads release the shared lines as data enable falls
               oe_nxt    = is_write(kind_r);
               ad_out_nxt = fifo_data;
            end
            ST_DATA: begin
               if (beat_ok) begin
                  if (is_write(kind_r)) begin
                     fifo_pop = 1'b1;
                  end else begin
                     rdata_nxt  = ad_s2_r;
                     rvalid_nxt = 1'b1;
                  end
                  if (left_r == 4'h1) begin
                     st_nxt    = ST_IDLE;
                     den_n_nxt = 1'b1;
                     oe_nxt    = 1'b0;
                     done_nxt  = 1'b1;
                  end else begin
                     word_nxt   = word_r + 3'h1;
                     left_nxt   = left_r - 4'h1;
                     ad_out_nxt = fifo_data;
                  end
               end
            end
            ST_HOLD: begin
               if (!hold_s2_r) begin
                  st_nxt      = ST_IDLE;
                  hold_acknowledge_nxt    = 1'b0;
                  pins_oe_nxt = 1'b1;
               end
            end
         endcase
      end
      // second half of a write beat: show the next buffered word
      if (st_r == ST_DATA && is_write(kind_r) && !phase) begin
         ad_out_nxt = fifo_data;
      end
   end

   always_ff @(posedge clk_i) begin
      if (sys_rst_i) begin
         st_r      <= ST_IDLE;
         kind_r    <= KIND_READ;
         addr_r    <= '0;
         word_r    <= '0;
         left_r    <= '0;
         hold_acknowledge_r    <= 1'b0;
         ale_r     <= 1'b0;
         as_n_r    <= STROBE_IDLE;
         den_n_r   <= STROBE_IDLE;
         dir_r     <= DIR_RST;
         wnr_r     <= 1'b0;
         oe_r      <= 1'b0;
         pins_oe_r <= 1'b1;
         ad_out_r  <= '0;
         rdata_r   <= '0;
         rvalid_r  <= 1'b0;
         done_r    <= 1'b0;
         rready_r  <= 1'b0;
      end else begin
         st_r      <= st_nxt;
         kind_r    <= kind_nxt;
         addr_r    <= addr_nxt;
         word_r    <= word_nxt;
         left_r    <= left_nxt;
         hold_acknowledge_r    <= hold_acknowledge_nxt;
         ale_r     <= ale_nxt;
         as_n_r    <= as_n_nxt;
         den_n_r   <= den_n_nxt;
         dir_r     <= dir_nxt;
         wnr_r     <= wnr_nxt;
         oe_r      <= oe_nxt;
         pins_oe_r <= pins_oe_nxt;
         ad_out_r  <= ad_out_nxt;
         rdata_r   <= rdata_nxt;
         rvalid_r  <= rvalid_nxt;
         done_r    <= done_nxt;
         rready_r  <= rready_nxt;
      end
   end

   // every pin straight from a flip-flop
   assign req_ready_o                 = rready_r;
   assign rdata_o                     = rdata_r;
   assign rdata_valid_o               = rvalid_r;
   assign done_o                      = done_r;
   assign upper_address_lines_o       = addr_r[ADDR_W-1:UPPER_LSB];
   assign upper_address_oe_o          = pins_oe_r;
   assign shared_address_data_lines_o = ad_out_r;
   assign shared_address_data_oe_o    = oe_r;
   assign burst_word_address_lines_o  = word_r;
   assign address_latch_o             = ale_r;
   assign address_latch_oe_o          = pins_oe_r;
   assign address_status_strobe_n_o   = as_n_r;
   assign write_not_read_o            = wnr_r;
   assign data_enable_n_o             = den_n_r;
   assign transfer_direction_o        = dir_r;
   assign strobes_oe_o                = pins_oe_r;
   assign hold_acknowledge_o          = hold_acknowledge_r;

   sequence s_addr_then_data;
      !as_n_r && ale_r ##2 as_n_r && !ale_r && !den_n_r;
   endsequence
   property p_addr_seq;
      @(posedge clk_i) disable iff (sys_rst_i) $fell(as_n_r) |-> s_addr_then_data;
   endproperty
   a_addr_seq: assert property (p_addr_seq) else $error("address state malformed");
   property p_as_one_state;
      @(posedge clk_i) disable iff (sys_rst_i) $fell(as_n_r) |=> !as_n_r ##1 as_n_r;
   endproperty
   a_as_one_state: assert property (p_as_one_state) else $error("status strobe width");
   property p_dir_stable;
      @(posedge clk_i) disable iff (sys_rst_i) !den_n_r && !$past(den_n_r) |-> $stable(dir_r);
   endproperty
   a_dir_stable: assert property (p_dir_stable) else $error("direction moved in data");
   property p_dir_kind;
      @(posedge clk_i) disable iff (sys_rst_i) !den_n_r |-> dir_r == (kind_r == KIND_WRITE);
   endproperty
   a_dir_kind: assert property (p_dir_kind) else $error("direction wrong for kind");
   property p_upper_hold;
      @(posedge clk_i) disable iff (sys_rst_i) !den_n_r && !$past(den_n_r) |-> $stable(addr_r);
   endproperty
   a_upper_hold: assert property (p_upper_hold) else $error("upper address moved");
   property p_read_float;
      @(posedge clk_i) disable iff (sys_rst_i) !den_n_r && !wnr_r |-> !oe_r;
   endproperty
   a_read_float: assert property (p_read_float) else $error("driving during read");
   property p_wait;
      @(posedge clk_i) disable iff (sys_rst_i)
         st_r == ST_DATA && phase && rdy_s2_r |=> st_r == ST_DATA && $stable(word_r);
   endproperty
   a_wait: assert property (p_wait) else $error("wait not inserted");
   property p_hold_float;
      @(posedge clk_i) disable iff (sys_rst_i) hold_acknowledge_r |-> !address_latch_oe_o && !oe_r;
   endproperty
   a_hold_float: assert property (p_hold_float) else $error("pins driven in hold");
   property p_word_inc;
      @(posedge clk_i) disable iff (sys_rst_i)
         st_r == ST_DATA && $past(st_r) == ST_DATA && $changed(word_r)
         |-> word_r == $past(word_r) + 3'h1;
   endproperty
   a_word_inc: assert property (p_word_inc) else $error("word address not incremented");
   property p_den_outside;
      @(posedge clk_i) disable iff (sys_rst_i) st_r != ST_DATA |-> den_n_r;
   endproperty
   a_den_outside: assert property (p_den_outside) else $error("data enable outside data");
   property p_addr_shared;
      @(posedge clk_i) disable iff (sys_rst_i)
         st_r == ST_ADDRESS |-> ad_out_r == addr_r[15:0] && oe_r && ale_r && !as_n_r;
   endproperty
   a_addr_shared: assert property (p_addr_shared) else $error("address not on shared lines");
   property p_hold_ack;
      @(posedge clk_i) disable iff (sys_rst_i) st_r == ST_HOLD |-> hold_acknowledge_r && !pins_oe_r;
   endproperty
   a_hold_ack: assert property (p_hold_ack) else $error("hold without release");
endmodule // burst_bus_master

// ===== dv/mem_subsystem_model.sv
// memory and i/o subsystem with an address latch, far side of the burst bus
// assumes the bench resolves the shared lines from both parties' enables
`timescale 1ns/100ps
module mem_subsystem_model (
   input  wire logic        clk_i,
   input  wire logic [15:0] ad_i,
   input  wire logic        ale_i,
   input  wire logic [2:0]  word_i,
   input  wire logic        den_n_i,
   input  wire logic        dir_i,
   input  wire logic [3:0]  waits_i,
   output logic      [15:0] ad_o,
   output logic             ad_oe_o,
   output logic             ready_n_o
);
   logic [15:0] mem [128];
   logic [11:0] lat_r;
   logic [3:0]  cnt_r;
   logic [2:0]  word_r;
   logic [6:0]  idx;
   logic [3:0]  since;

   initial for (int i = 0; i < 128; i++) mem[i] = 16'hA000 + 16'(i);
   assign idx = {lat_r[2:0], word_i};
   // the shared lines carry data after the address state, so latch bits 15:4 now
   always @(posedge clk_i) begin
      if (ale_i) lat_r <= ad_i[15:4];
      if (!den_n_i && dir_i) mem[idx] <= ad_i;
      word_r <= word_i;
      cnt_r  <= (den_n_i || word_r != word_i) ? 4'h0 : cnt_r + 4'h1;
   end
   // drive only while data enable is low on a read or acknowledge; otherwise stay off the lines
   assign ad_oe_o   = !den_n_i && !dir_i;
   assign ad_o      = mem[idx];
   // ready held off for a set count, then low one internal cycle in every two;
   // a longer low would be seen stale by the device's two-flop sampling next beat
   assign since     = cnt_r - waits_i;
   assign ready_n_o = den_n_i || (cnt_r < waits_i) || since[1];
endmodule // mem_subsystem_model

// ===== dv/multiplexed_burst_bus_master_tb.sv
// self-checking bench for the burst bus master with a memory model behind it
// assumes the package and design files are compiled first
`timescale 1ns/100ps
module multiplexed_burst_bus_master_tb;
   import burst_bus_pkg::*;
   logic        clk_i = 1'b0, sys_rst_i = 1'b1, req_valid_i = 1'b0;
   logic        wdata_valid_i = 1'b0, hold_request_i = 1'b0;
   kind_t       req_kind_i = KIND_READ;
   logic [31:0] req_addr_i = 32'h0;
   logic [3:0]  req_beats_i = 4'h1, waits = 4'h0;
   logic [15:0] wdata_i = 16'h0, rdata_o, upper_address_lines_o, ad_out, mdl_ad, bus;
   logic [15:0] last_bus = 16'h0;
   logic [15:0] exp_mem [128];
   logic [2:0]  burst_word_address_lines_o;
   logic        req_ready_o, wdata_ready_o, rdata_valid_o, done_o, upper_address_oe_o;
   logic        shared_address_data_oe_o, address_latch_o, address_latch_oe_o;
   logic        address_status_strobe_n_o, write_not_read_o, data_enable_n_o;
   logic        transfer_direction_o, strobes_oe_o, ready_n_i, hold_acknowledge_o;
   logic        mdl_oe, den_prev = 1'b1, dir_prev = 1'b1;
   int          err_count = 0, num_checks = 0, cyc = 0;

   always #5 clk_i = ~clk_i;
   initial for (int i = 0; i < 128; i++) exp_mem[i] = 16'hA000 + 16'(i);
   // released lines show a changing pattern, the bus value of the previous clock inverted
   assign bus = shared_address_data_oe_o ? ad_out : (mdl_oe ? mdl_ad : ~last_bus);
   always @(posedge clk_i) last_bus <= bus;

   burst_bus_master dut (.clk_i, .sys_rst_i, .req_valid_i, .req_ready_o, .req_kind_i,
      .req_addr_i, .req_beats_i, .wdata_i, .wdata_valid_i, .wdata_ready_o, .rdata_o,
      .rdata_valid_o, .done_o, .upper_address_lines_o, .upper_address_oe_o,
      .shared_address_data_lines_i(bus), .shared_address_data_lines_o(ad_out),
      .shared_address_data_oe_o, .burst_word_address_lines_o, .address_latch_o,
      .address_latch_oe_o, .address_status_strobe_n_o, .write_not_read_o,
      .data_enable_n_o, .transfer_direction_o, .strobes_oe_o, .ready_n_i,
      .hold_request_i, .hold_acknowledge_o);

   mem_subsystem_model mdl (.clk_i, .ad_i(bus), .ale_i(address_latch_o),
      .word_i(burst_word_address_lines_o), .den_n_i(data_enable_n_o),
      .dir_i(transfer_direction_o), .waits_i(waits), .ad_o(mdl_ad), .ad_oe_o(mdl_oe),
      .ready_n_o(ready_n_i));

   task automatic check(input logic ok, input string msg);
      num_checks++;
      if (ok !== 1'b1) begin
         err_count++;
         $display("Error at %0t: %s", $time, msg);
      end
   endtask

   task automatic tally_and_finish();
      $display("checks %0d, mismatches %0d", num_checks, err_count);
      if (err_count == 0 && num_checks > 0) $display("ALL TESTS PASSED");
      else $display("TESTS FAILED");
      $finish;
   endtask

   // hang guard: a full run needs far fewer cycles than this
   always @(posedge clk_i) begin
      cyc++;
      if (cyc == 20000) begin
         err_count++;
         tally_and_finish();
      end
   end

   // cycle watch on the pins across all scenarios
   always @(negedge clk_i) begin
      if (den_prev === 1'b0 && data_enable_n_o === 1'b0 && transfer_direction_o !== dir_prev)
         check(1'b0, "direction moved with data enable low");
      if (data_enable_n_o === 1'b0 && !transfer_direction_o && shared_address_data_oe_o)
         check(1'b0, "shared lines driven during a read");
      if (hold_acknowledge_o === 1'b1 && address_latch_oe_o !== 1'b0)
         check(1'b0, "latch strobe driven while held");
      den_prev <= data_enable_n_o;
      dir_prev <= transfer_direction_o;
   end

   // one transaction: fill write data, request, check address state, follow beats
   task automatic xfer(input kind_t k, input logic [31:0] a, input int nb,
                       input logic [3:0] w, output int n);
      logic [6:0] ix;
      logic       wr, ok;
      int         got;
      wr = (k == KIND_WRITE);
      ok = 1'b1;
      got = 0;
      waits = w;
      for (int i = 0; i < nb && wr; i++) begin
         n = 0;
         while (wdata_ready_o !== 1'b1 && n < 50) begin @(negedge clk_i); n++; end
         ix = {a[6:4], a[3:1] + 3'(i)};
         exp_mem[ix] = {a[11:4], 5'h0A, 3'(i)};
         wdata_i = exp_mem[ix];
         wdata_valid_i = 1'b1;
         @(negedge clk_i);
      end
      if (wr && nb == 8) check(wdata_ready_o === 1'b0, "fifo took a ninth word");
      wdata_valid_i = 1'b0;
      req_kind_i = k;
      req_addr_i = a;
      req_beats_i = 4'(nb);
      req_valid_i = 1'b1;
      n = 0;
      while (req_ready_o !== 1'b1 && n < 200) begin @(negedge clk_i); n++; end
      req_valid_i = 1'b0;
      check(n < 200, "request not taken");
      n = 0;
      while (address_latch_o !== 1'b1 && n < 20) begin @(negedge clk_i); n++; end
      check(address_status_strobe_n_o === 1'b0 && bus === a[15:0], "address state");
      check(upper_address_lines_o === a[31:16], "upper address");
      check(burst_word_address_lines_o === a[3:1], "word lines");
      check(write_not_read_o === wr && transfer_direction_o === wr, "kind flags");
      n = 0;
      while (done_o !== 1'b1 && n < 400) begin
         @(negedge clk_i);
         n++;
         if (upper_address_lines_o !== a[31:16] || write_not_read_o !== wr) ok = 1'b0;
         if (!data_enable_n_o && (address_latch_o || !address_status_strobe_n_o)) ok = 1'b0;
         if (rdata_valid_o === 1'b1) begin
            ix = {a[6:4], a[3:1] + 3'(got)};
            check(rdata_o === exp_mem[ix], "read data");
            got++;
         end
      end
      check(n < 400 && ok, "burst hung or pins moved in data states");
      check(got == (wr ? 0 : nb), "read beat count");
      for (int i = 0; i < nb && wr; i++) begin
         ix = {a[6:4], a[3:1] + 3'(i)};
         check(mdl.mem[ix] === exp_mem[ix], "written word");
      end
   endtask

   task automatic t_reset();
      check(address_status_strobe_n_o === 1'b1 && data_enable_n_o === 1'b1, "strobes");
      check(transfer_direction_o === 1'b1 && hold_acknowledge_o === 1'b0, "reset pins");
      $display("test reset done");
   endtask

   task automatic t_burst();
      int fast, slow;
      xfer(KIND_WRITE, 32'h1234_5670, 8, 4'h0, fast);
      check(fast >= 16, "data state shorter than two clocks");
      xfer(KIND_READ, 32'h1234_5670, 8, 4'h0, fast);
      xfer(KIND_READ, 32'h1234_5670, 8, 4'h3, slow);
      check(slow > fast, "no wait states");
      $display("test burst done");
   endtask

   task automatic t_back_to_back();
      int n;
      xfer(KIND_WRITE, 32'hABCD_002C, 4, 4'h1, n);
      xfer(KIND_INTACK, 32'hABCD_002C, 4, 4'h0, n);
      xfer(KIND_READ, 32'h0000_0002, 1, 4'h0, n);
      $display("test back to back done");
   endtask

   task automatic t_hold();
      int n;
      hold_request_i = 1'b1;
      n = 0;
      while (hold_acknowledge_o !== 1'b1 && n < 50) begin @(negedge clk_i); n++; end
      check(n < 50 && !shared_address_data_oe_o && !address_latch_oe_o, "hold");
      check(!upper_address_oe_o && !strobes_oe_o, "address or strobe pins driven in hold");
      req_kind_i = KIND_READ;
      req_beats_i = 4'h1;
      req_valid_i = 1'b1;
      repeat (20) begin @(negedge clk_i); if (req_ready_o === 1'b1) n = 999; end
      check(n < 999, "request taken while held");
      req_valid_i = 1'b0;
      hold_request_i = 1'b0;
      n = 0;
      while (hold_acknowledge_o !== 1'b0 && n < 50) begin @(negedge clk_i); n++; end
      check(n < 50, "hold not released");
      check(upper_address_oe_o === 1'b1 && strobes_oe_o === 1'b1, "pins not back");
      xfer(KIND_READ, 32'h1234_5674, 2, 4'h0, n);
      $display("test hold done");
   endtask

   initial begin
      repeat (10) @(negedge clk_i);
      t_reset();
      repeat (6) @(negedge clk_i);
      sys_rst_i = 1'b0;
      @(negedge clk_i);
      t_burst();
      t_back_to_back();
      t_hold();
      tally_and_finish();
   end
endmodule // multiplexed_burst_bus_master_tb
